/* hdl/pin_cfg_defs.vh */
`ifndef PIN_CFG_DEFS_VH
`define PIN_CFG_DEFS_VH
// ****************************************
// register offsets and reset values
// ****************************************
`define OFS_PIN_SETUP_ONE   8'ha4
`define OFS_PIN_SETUP_TWO   8'ha6
`define OFS_DEVICE_SETUP    8'ha8
`define RST_PIN_SETUP_ONE   32'h00000000
`define RST_PIN_SETUP_TWO   32'h00000000
`define RST_DEVICE_SETUP    32'h00000000
// ****************************************
// field positions
// ****************************************
`define MON1_HI             30
`define MON1_LO             19
`define MON2_HI             18
`define MON2_LO             7
`define BRAKE_HI            6
`define BRAKE_LO            5
`define DIR_HI              4
`define DIR_LO              3
`define SPD_HI              2
`define SPD_LO              1
`define MPIN_HI             30
`define MPIN_LO             29
`define XTAL_BIT            27
`define SLEEP_HI            19
`define SLEEP_LO            18
`define WD_EN_BIT           17
`define WD_SRC_BIT          16
`define WD_REACT_BIT        15
`define WD_FREQ_HI          14
`define WD_FREQ_LO          13
// ****************************************
// timing: sleep low times in us, cycles at 125 MHz
// ****************************************
`define CLK_MHZ             125
`define SLEEP_T0_US         50
`define SLEEP_T1_US         200
`define SLEEP_T2_US         20000
`define SLEEP_T3_US         200000
`define SLEEP_C0            (`SLEEP_T0_US * `CLK_MHZ)
`define SLEEP_C1            (`SLEEP_T1_US * `CLK_MHZ)
`define SLEEP_C2            (`SLEEP_T2_US * `CLK_MHZ)
`define SLEEP_C3            (`SLEEP_T3_US * `CLK_MHZ)
// watchdog periods in ms for freq codes 10, 5, 2, 1 Hz
`define WD_T0_MS            100
`define WD_T1_MS            200
`define WD_T2_MS            500
`define WD_T3_MS            1000
`define WD_C0               (`WD_T0_MS * 1000 * `CLK_MHZ)
`define WD_C1               (`WD_T1_MS * 1000 * `CLK_MHZ)
`define WD_C2               (`WD_T2_MS * 1000 * `CLK_MHZ)
`define WD_C3               (`WD_T3_MS * 1000 * `CLK_MHZ)
`endif

/* hdl/hw_pin_config_regs.v */
// Operation
// - first pin setup register at A4h, resets to all zeros.
// - second pin setup register at A6h, resets to all zeros.
// - two 12-bit monitor variable selects at bits 30-19 and 18-7.
// - brake source: pin, forced brake, brake disabled; code 3 unused.
// - direction source: pin or forced clockwise A-B-C; codes 2 and 3 unused.
// - speed source: analog, PWM, serial, frequency.
// - multi pin carries monitor two or phase A/B/C sense.
// - crystal pins carry monitors one and two when bit 27 set.
// - bit 17 enables watchdog; bit 16 picks serial or pin kick.
// - bit 15: report expiry only, or latch fault with outputs Hi-Z.
`timescale 1ns/1ns
`include "pin_cfg_defs.vh"
module hw_pin_config_regs #(
  parameter [31:0] SLEEP_C0 = `SLEEP_C0,
  parameter [31:0] SLEEP_C1 = `SLEEP_C1,
  parameter [31:0] SLEEP_C2 = `SLEEP_C2,
  parameter [31:0] SLEEP_C3 = `SLEEP_C3,
  parameter [31:0] WD_C0    = `WD_C0,
  parameter [31:0] WD_C1    = `WD_C1,
  parameter [31:0] WD_C2    = `WD_C2,
  parameter [31:0] WD_C3    = `WD_C3
) (
  // clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // register access from the serial interface block
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  output reg  [31:0] reg_rdata,
  output reg         reg_rvalid,
  // serial speed value, serial watchdog kick and fault clear
  input  wire [15:0] serial_speed,
  input  wire        serial_kick,
  input  wire        fault_clear,
  // device pins (asynchronous)
  input  wire        brake_pin,
  input  wire        dir_pin,
  input  wire        kick_pin,
  input  wire        sleep_pin,
  input  wire [15:0] analog_speed,
  input  wire [15:0] pwm_speed,
  input  wire [15:0] freq_speed,
  // monitor data and phase sense
  input  wire [15:0] var_one_data,
  input  wire [15:0] var_two_data,
  input  wire [15:0] sense_a,
  input  wire [15:0] sense_b,
  input  wire [15:0] sense_c,
  // configuration results
  output reg  [11:0] monitor_one_var_sel,
  output reg  [11:0] monitor_two_var_sel,
  output reg         brake_active,
  output reg         dir_clockwise,
  output reg  [15:0] speed_command,
  output reg  [15:0] multi_pin_out,
  output reg  [15:0] crystal_pin_one,
  output reg  [15:0] crystal_pin_two,
  output reg         crystal_pins_en,
  output reg         sleep_enter,
  output reg         watchdog_expired,
  output reg         watchdog_fault,
  output reg         outputs_hiz
);

  // ****************************************
  // registers
  // ****************************************
  reg [31:0] one_q, two_q, dev_q;
  reg [1:0]  brk_s, dir_s, kick_s, slp_s;
  reg        kick_d1_q;
  reg [31:0] slp_cnt_q, wd_cnt_q;
  reg [31:0] slp_lim, wd_lim;
  wire       kick_sel;
  wire       kick_ev;

  // register writes; unmapped offsets are ignored
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      one_q <= `RST_PIN_SETUP_ONE;
      two_q <= `RST_PIN_SETUP_TWO;
      dev_q <= `RST_DEVICE_SETUP;
    end else if (reg_wr) begin
      case (reg_addr)
        `OFS_PIN_SETUP_ONE: one_q <= reg_wdata;
        `OFS_PIN_SETUP_TWO: two_q <= reg_wdata;
        `OFS_DEVICE_SETUP:  dev_q <= reg_wdata;
        default:            one_q <= one_q;
      endcase
    end
  end

  // reads answer one cycle later; reserved offsets read zero
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata  <= 32'h00000000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      case (reg_addr)
        `OFS_PIN_SETUP_ONE: reg_rdata <= one_q;
        `OFS_PIN_SETUP_TWO: reg_rdata <= two_q;
        `OFS_DEVICE_SETUP:  reg_rdata <= dev_q;
        default:            reg_rdata <= 32'h00000000;
      endcase
    end
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  // two flops each; only the second stage (bit 1) is read by logic
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      brk_s  <= 2'h0;
      dir_s  <= 2'h0;
      kick_s <= 2'h0;
      slp_s  <= 2'h3;
    end else begin
      brk_s  <= {brk_s[0], brake_pin};
      dir_s  <= {dir_s[0], dir_pin};
      kick_s <= {kick_s[0], kick_pin};
      slp_s  <= {slp_s[0], sleep_pin};
    end
  end

  // ****************************************
  // source selection and pin routing
  // ****************************************
  // multi-bit analog values assumed stable from their converters
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      monitor_one_var_sel <= 12'h000;
      monitor_two_var_sel <= 12'h000;
      brake_active        <= 1'b0;
      dir_clockwise       <= 1'b0;
      speed_command       <= 16'h0000;
      multi_pin_out       <= 16'h0000;
      crystal_pin_one     <= 16'h0000;
      crystal_pin_two     <= 16'h0000;
      crystal_pins_en     <= 1'b0;
    end else begin
      monitor_one_var_sel <= one_q[`MON1_HI:`MON1_LO];
      monitor_two_var_sel <= one_q[`MON2_HI:`MON2_LO];
      case (one_q[`BRAKE_HI:`BRAKE_LO])
        2'h0:    brake_active <= brk_s[1];
        2'h1:    brake_active <= 1'b1;
        2'h2:    brake_active <= 1'b0;
        default: brake_active <= brk_s[1]; // unused code acts as pin
      endcase
      case (one_q[`DIR_HI:`DIR_LO])
        2'h1:    dir_clockwise <= 1'b1;
        default: dir_clockwise <= dir_s[1];
      endcase
      case (one_q[`SPD_HI:`SPD_LO])
        2'h0:    speed_command <= analog_speed;
        2'h1:    speed_command <= pwm_speed;
        2'h2:    speed_command <= serial_speed;
        default: speed_command <= freq_speed;
      endcase
      case (two_q[`MPIN_HI:`MPIN_LO])
        2'h0:    multi_pin_out <= var_two_data;
        2'h1:    multi_pin_out <= sense_a;
        2'h2:    multi_pin_out <= sense_b;
        default: multi_pin_out <= sense_c;
      endcase
      // cleared bit has no function, so pins are left idle
      crystal_pins_en <= two_q[`XTAL_BIT];
      crystal_pin_one <= two_q[`XTAL_BIT] ? var_one_data : 16'h0000;
      crystal_pin_two <= two_q[`XTAL_BIT] ? var_two_data : 16'h0000;
    end
  end

  // ****************************************
  // sleep qualification
  // ****************************************
  always @* begin
    case (two_q[`SLEEP_HI:`SLEEP_LO])
      2'h0:    slp_lim = SLEEP_C0;
      2'h1:    slp_lim = SLEEP_C1;
      2'h2:    slp_lim = SLEEP_C2;
      default: slp_lim = SLEEP_C3;
    endcase
  end

  // any high sample restarts the count, so glitches never sleep the part
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      slp_cnt_q   <= 32'h00000000;
      sleep_enter <= 1'b0;
    end else if (slp_s[1]) begin
      slp_cnt_q   <= 32'h00000000;
      sleep_enter <= 1'b0;
    end else if (slp_cnt_q < slp_lim) begin
      slp_cnt_q   <= slp_cnt_q + 32'h00000001;
      sleep_enter <= 1'b0;
    end else begin
      sleep_enter <= 1'b1;
    end
  end

  // ****************************************
  // external watchdog
  // ****************************************
  always @* begin
    case (two_q[`WD_FREQ_HI:`WD_FREQ_LO])
      2'h0:    wd_lim = WD_C0;
      2'h1:    wd_lim = WD_C1;
      2'h2:    wd_lim = WD_C2;
      default: wd_lim = WD_C3;
    endcase
  end

  assign kick_sel = two_q[`WD_SRC_BIT];
  assign kick_ev  = kick_sel ? (kick_s[1] & ~kick_d1_q) : serial_kick;

  // expiry pulses once per missed period; fault latches until cleared
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      kick_d1_q        <= 1'b0;
      wd_cnt_q         <= 32'h00000000;
      watchdog_expired <= 1'b0;
      watchdog_fault   <= 1'b0;
      outputs_hiz      <= 1'b0;
    end else begin
      kick_d1_q        <= kick_s[1];
      watchdog_expired <= 1'b0;
      if (!two_q[`WD_EN_BIT] || kick_ev) begin
        wd_cnt_q <= 32'h00000000;
      end else if (wd_cnt_q + 32'h00000001 >= wd_lim) begin
        wd_cnt_q         <= 32'h00000000;
        watchdog_expired <= 1'b1;
      end else begin
        wd_cnt_q <= wd_cnt_q + 32'h00000001;
      end
      // set wins over clear
      if (watchdog_expired && two_q[`WD_REACT_BIT]) begin
        watchdog_fault <= 1'b1;
        outputs_hiz    <= 1'b1;
      end else if (fault_clear) begin
        watchdog_fault <= 1'b0;
        outputs_hiz    <= 1'b0;
      end
    end
  end

endmodule // hw_pin_config_regs

/* sim/host_model.sv */
`timescale 1ns/1ns
module host_model (
  // clock and read answer
  input  wire         clk,
  input  wire  [31:0] reg_rdata,
  input  wire         reg_rvalid,
  // register requests and serial kick
  output logic        reg_wr      = 1'b0,
  output logic        reg_rd      = 1'b0,
  output logic [7:0]  reg_addr    = 8'h0,
  output logic [31:0] reg_wdata   = 32'h0,
  output logic        serial_kick = 1'b0
);
  // ****************************************
  // host requests
  // ****************************************
  // change after the falling edge, held across one rising edge; released lines flip
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  // a missing answer strobe turns the word round so that no expectation can match
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = (reg_rvalid === 1'b1) ? reg_rdata : ~reg_rdata;
  endtask
  // one-cycle kick, well inside the shortest period
  task automatic kick;
    @(negedge clk);
    serial_kick = 1'b1;
    @(negedge clk);
    serial_kick = 1'b0;
  endtask
endmodule // host_model

/* sim/hw_pin_config_sva.sv */
`timescale 1ns/1ns
module hw_pin_config_sva (
  // clock, reset, register access and sleep pin
  input wire        clk,
  input wire        sys_rst,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [7:0]  reg_addr,
  input wire [31:0] reg_wdata,
  input wire [31:0] reg_rdata,
  input wire        reg_rvalid,
  input wire        sleep_pin,
  // configuration results
  input wire [11:0] monitor_one_var_sel,
  input wire [11:0] monitor_two_var_sel,
  input wire [15:0] crystal_pin_one,
  input wire [15:0] crystal_pin_two,
  input wire        crystal_pins_en,
  input wire        sleep_enter,
  input wire        watchdog_expired,
  input wire        watchdog_fault,
  input wire        outputs_hiz
);
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_rst; $fell(sys_rst) |-> !reg_rvalid && monitor_one_var_sel == 12'h0 && !outputs_hiz; endproperty
  a_rst: assert property (p_rst) else $error("outputs not clear after reset");
  property p_resv; reg_rd && !(reg_addr inside {8'ha4, 8'ha6, 8'ha8}) |=> reg_rdata == 32'h0; endproperty
  a_resv: assert property (p_resv) else $error("reserved offset read nonzero");
  property p_rd_one; reg_rd && reg_addr == 8'ha4 |=> reg_rdata[30:7] == {monitor_one_var_sel, monitor_two_var_sel}; endproperty
  a_rd_one: assert property (p_rd_one) else $error("monitor selects differ from register");
  property p_wr_one; reg_wr && reg_addr == 8'ha4 |=> ##2 monitor_one_var_sel == $past(reg_wdata[30:19], 3); endproperty
  a_wr_one: assert property (p_wr_one) else $error("monitor one select not updated");
  property p_wr_two; reg_wr && reg_addr == 8'ha6 ##1 !reg_wr ##1 reg_rd && reg_addr == 8'ha6 |=> reg_rdata == $past(reg_wdata, 3); endproperty
  a_wr_two: assert property (p_wr_two) else $error("second register readback wrong");
  property p_xtal; !crystal_pins_en |-> crystal_pin_one == 16'h0 && crystal_pin_two == 16'h0; endproperty
  a_xtal: assert property (p_xtal) else $error("crystal pins driven while off");
  property p_sleep; sleep_pin [*5] |-> !sleep_enter; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep held with input high");
  property p_pulse; watchdog_expired |=> !watchdog_expired; endproperty
  a_pulse: assert property (p_pulse) else $error("expiry longer than one cycle");
  property p_hiz; $rose(watchdog_fault) |-> outputs_hiz; endproperty
  a_hiz: assert property (p_hiz) else $error("fault without high impedance");
  c_sleep: cover property (sleep_enter);
  c_fault: cover property (watchdog_fault);
  c_xtal: cover property (crystal_pins_en);
endmodule // hw_pin_config_sva
bind hw_pin_config_regs hw_pin_config_sva chk (.*);

/* sim/hw_pin_config_regs_tb.sv */
`timescale 1ns/1ns
module hw_pin_config_regs_tb;
  // ****************************************
  // stimulus, device and checks
  // ****************************************
  logic clk = 1'b0, sys_rst = 1'b1, fault_clear = 1'b0;
  logic brake_pin = 1'b0, dir_pin = 1'b0, kick_pin = 1'b0, sleep_pin = 1'b1;
  logic [15:0] base = 16'h0;
  wire [15:0] analog_speed = base ^ 16'h1111, pwm_speed = base ^ 16'h2222;
  wire [15:0] freq_speed = base ^ 16'h3333, serial_speed = base ^ 16'h4444;
  wire [15:0] var_one_data = base ^ 16'h5555, var_two_data = base ^ 16'h6666;
  wire [15:0] sense_a = base ^ 16'h7777, sense_b = base ^ 16'h8888, sense_c = base ^ 16'h9999;
  wire reg_wr, reg_rd, reg_rvalid, serial_kick, brake_active, dir_clockwise, crystal_pins_en;
  wire sleep_enter, watchdog_expired, watchdog_fault, outputs_hiz;
  wire [7:0] reg_addr;
  wire [31:0] reg_wdata, reg_rdata;
  wire [11:0] monitor_one_var_sel, monitor_two_var_sel;
  wire [15:0] speed_command, multi_pin_out, crystal_pin_one, crystal_pin_two;
  int bad_count = 0, samples_checked = 0, cycles = 0, exp_cnt = 0;
  logic [31:0] rd_v, w1, w2;
  always #4 clk = ~clk;
  // short counts keep the run brief; only the 10 Hz watchdog period is exercised
  hw_pin_config_regs #(.SLEEP_C0(32'h8), .SLEEP_C1(32'h10), .SLEEP_C2(32'h20), .SLEEP_C3(32'h40),
    .WD_C0(32'h28)) dut (.*);
  host_model host (.*);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic final_report;
    if (bad_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask
  // kicks from the selected source only; the other source stays quiet
  task automatic wd_run(input logic [31:0] cfg, input bit kick_on);
    int start_cnt;
    host.wr(8'ha6, cfg);
    start_cnt = exp_cnt;
    repeat (20) begin
      wait_n(6);
      if (kick_on && cfg[16]) kick_pin = ~kick_pin;
      else if (kick_on) host.kick;
    end
    chk(kick_on ? exp_cnt == start_cnt : exp_cnt - start_cnt >= 2, 1);
    chk({watchdog_fault, outputs_hiz}, {2{cfg[15] & ~kick_on}});
  endtask
  // cycle ceiling and expiry pulse count
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (watchdog_expired === 1'b1) exp_cnt <= exp_cnt + 1;
    if (cycles == 20000) begin
      bad_count++;
      final_report;
    end
  end
  initial begin
    wait_n(3);
    sys_rst = 1'b0;
    host.rd(8'ha4, rd_v);
    chk(rd_v, 32'h0);
    host.rd(8'ha6, rd_v);
    chk(rd_v, 32'h0);
    for (int p = 0; p < 2; p++) for (int c = 0; c < 4; c++) begin
      brake_pin = p[0];
      dir_pin = ~p[0];
      base = 16'h0101 * c;
      w1 = {1'b1, 10'h295, c[1:0], c[1:0], 10'h0f3, c[1:0], c[1:0], c[1:0], 1'b1};
      w2 = {1'b1, c[1:0], 1'b0, p[0], 27'h0};
      host.wr(8'ha4, w1);
      host.wr(8'ha6, w2);
      wait_n(5);
      chk({monitor_one_var_sel, monitor_two_var_sel}, w1[30:7]);
      chk(brake_active, c == 1 ? 1'b1 : c == 2 ? 1'b0 : p[0]);
      chk(dir_clockwise, c == 1 ? 1'b1 : dir_pin);
      chk(speed_command, c == 0 ? analog_speed : c == 1 ? pwm_speed : c == 2 ? serial_speed : freq_speed);
      chk(multi_pin_out, c == 0 ? var_two_data : c == 1 ? sense_a : c == 2 ? sense_b : sense_c);
      chk(crystal_pins_en, p[0]);
      chk({crystal_pin_one, crystal_pin_two}, p ? {var_one_data, var_two_data} : 32'h0);
      host.rd(8'ha4, rd_v);
      chk(rd_v, w1);
      host.rd(8'ha6, rd_v);
      chk(rd_v, w2);
    end
    for (int i = 0; i < 4; i++) begin
      host.wr(8'ha5 + 8'h2 * i[7:0], 32'hffffffff);
      host.rd(8'ha5 + 8'h2 * i[7:0], rd_v);
      chk(rd_v, 32'h0);
    end
    host.rd(8'ha4, rd_v);
    chk(rd_v, w1);
    for (int k = 0; k < 4; k++) begin
      host.wr(8'ha6, {12'h0, k[1:0], 18'h0});
      host.rd(8'ha6, rd_v);
      chk(rd_v, {12'h0, k[1:0], 18'h0});
      sleep_pin = 1'b0;
      wait_n(4 << k);
      chk(sleep_enter, 1'b0);
      wait_n((8 << k) + 8);
      chk(sleep_enter, 1'b1);
      sleep_pin = 1'b1;
      wait_n(5);
    end
    wd_run(32'h00020000, 1'b1);
    wd_run(32'h00030000, 1'b1);
    wd_run(32'h00020000, 1'b0);
    wd_run(32'h00028000, 1'b0);
    host.wr(8'ha6, 32'h0);
    fault_clear = 1'b1;
    wait_n(3);
    fault_clear = 1'b0;
    wait_n(2);
    chk({watchdog_fault, outputs_hiz}, 2'h0);
    final_report;
  end
endmodule // hw_pin_config_regs_tb
